// >>> atc_defs.vh
// constants for the converter trigger and configuration block
`ifndef ATC_DEFS_VH
`define ATC_DEFS_VH
// register indexes; byte address is four times the index
`define ATC_IDX_CONV_B      6'h01
`define ATC_IDX_REF         6'h02
`define ATC_IDX_EVT         6'h03
`define ATC_IDX_DIV         6'h04
// reset values
`define ATC_RST_CONV_B      8'h00
`define ATC_RST_REF         8'h00
`define ATC_RST_EVT         8'h00
`define ATC_RST_DIV         8'h00
// writable masks, reserved bits read zero
`define ATC_MASK_CONV_B     8'h8E
`define ATC_MASK_REF        8'h73
`define ATC_MASK_EVT        8'hFF
`define ATC_MASK_DIV        8'h07
// conversion_control_b fields
`define ATC_CB_IMP          7
`define ATC_CB_FREE         3
`define ATC_CB_FMT_HI       2
`define ATC_CB_FMT_LO       1
// reference_control fields
`define ATC_RF_SEL_HI       6
`define ATC_RF_SEL_LO       4
`define ATC_RF_BANDGAP      1
`define ATC_RF_TEMP         0
// event_trigger_control fields
`define ATC_EV_SCAN_HI      7
`define ATC_EV_SCAN_LO      6
`define ATC_EV_GRP_HI       5
`define ATC_EV_GRP_LO       3
`define ATC_EV_ACT_HI       2
`define ATC_EV_ACT_LO       0
// clock_divider_control field
`define ATC_DV_HI           2
`define ATC_DV_LO           0
// result formats
`define ATC_FMT_R12         2'b00
`define ATC_FMT_RSVD        2'b01
`define ATC_FMT_R8          2'b10
`define ATC_FMT_L12         2'b11
// event actions
`define ATC_ACT_NONE        3'b000
`define ATC_ACT_CH0123      3'b100
`define ATC_ACT_SWEEP       3'b101
`define ATC_ACT_SYNC        3'b110
`define ATC_ACT_RSVD        3'b111
// gain codes below this allow the high-impedance stage (1x..8x)
`define ATC_GAIN_HIZ_LIMIT  3'b100
// smallest converter clock division factor
`define ATC_DIV_BASE        9'h004
// ahb
`define ATC_HTRANS_NONSEQ   2'b10
`define ATC_HTRANS_SEQ      2'b11
`endif

// >>> atc_ctrl.v
// converter trigger selection, sweep sequencing, clock divider and result formatting
`timescale 1ns/1ps
`include "atc_defs.vh"

// Functional notes
// - continuous flag set: sweep the scan range again and again without software
// - format 00 right 12-bit, 10 right 8-bit, 11 left 12-bit, 01 reserved
// - each result is placed in a 16-bit result word, aligned per format
// - high-impedance gain stage only for gains 1x to 8x, otherwise forced low
// - reference select bits 6:4 pick the reference, 101 to 111 reserved
// - bandgap enable bit 1 requests the bandgap for conversions
// - temperature enable bit 0 switches the temperature sensor on
// - scan range bits 7:6 cover channel 0 up to channel 0-3
// - group bits 5:3 pick consecutive event lines from that line, cut above 7
// - action 000 ignores events, 001-100 let 1-4 lines start channels 0-3
// - action 101: event on lowest chosen line starts one sweep
// - action 110: flush, restart converter clock, then one sweep
// - divider register holds bits 2:0, bits 7:3 read zero
// - converter clock is peripheral clock divided by 4 up to 512
// - flush aborts conversions, clock restarts on the same edge as the flush, pending work resumes
// - several requests in one converter period: lowest channel first
module atc_ctrl (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        clk_en,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  input  wire [7:0]  event_lines,
  input  wire [11:0] channel_gain,
  input  wire        raw_valid,
  input  wire [1:0]  raw_channel,
  input  wire [11:0] raw_result,
  output reg         conv_clk_tick,
  output reg         pipeline_flush,
  output reg         conv_start,
  output reg  [1:0]  conv_channel,
  output reg  [3:0]  gain_stage_low_imp,
  output reg  [2:0]  reference_source_sel,
  output reg         bandgap_request,
  output reg         temp_sensor_enable,
  output reg         result_valid,
  output reg  [1:0]  result_channel,
  output reg  [15:0] result_word
);

  reg  [7:0] conv_b;
  reg  [7:0] ref_ctl;
  reg  [7:0] evt_ctl;
  reg  [7:0] div_ctl;
  reg        wr_pend;
  reg  [5:0] wr_idx;
  reg  [3:0] pending;
  reg  [8:0] div_cnt;

  wire       addr_ok;
  wire       req;
  wire [1:0] result_fmt;
  wire       continuous_sweep_flag;
  wire [1:0] scan_range;
  wire [2:0] event_line_group_sel;
  wire [2:0] event_action_sel;
  wire [9:0] div_full;
  wire [8:0] div_limit;
  wire [3:0] pend_view;
  wire [3:0] scan_mask;
  wire [3:0] direct_set;
  wire       sweep_event;
  wire       timed_scan_with_restart;
  wire       free_reload;
  wire [3:0] sweep_set;
  wire       tick_now;
  wire [3:0] start_onehot;

  reg  [7:0] next_rd;
  reg  [1:0] next_chan;
  reg  [15:0] next_word;

  assign req     = hsel & hready & htrans[1];
  assign addr_ok = (haddr[31:8] == 24'h0000_00) & (haddr[1:0] == 2'b00);

  assign result_fmt            = conv_b[`ATC_CB_FMT_HI:`ATC_CB_FMT_LO];
  assign continuous_sweep_flag = conv_b[`ATC_CB_FREE];
  assign scan_range            = evt_ctl[`ATC_EV_SCAN_HI:`ATC_EV_SCAN_LO];
  assign event_line_group_sel  = evt_ctl[`ATC_EV_GRP_HI:`ATC_EV_GRP_LO];
  assign event_action_sel      = evt_ctl[`ATC_EV_ACT_HI:`ATC_EV_ACT_LO];

  // factor 4 shifted by code; code 7 needs a tenth bit before the cut
  assign div_full  = ({1'b0, `ATC_DIV_BASE} << div_ctl[`ATC_DV_HI:`ATC_DV_LO]) - 10'h001;
  assign div_limit = div_full[8:0];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_chan
      assign scan_mask[gi] = (gi <= scan_range);
      // line group mapping, lines above 7 drop out
      assign direct_set[gi] = (event_action_sel != `ATC_ACT_NONE) &
                              (event_action_sel <= `ATC_ACT_CH0123) &
                              (gi < event_action_sel) &
                              ({1'b0, event_line_group_sel} + gi <= 7) &
                              event_lines[(event_line_group_sel + gi) & 7];
    end
  endgenerate

  assign sweep_event = ((event_action_sel == `ATC_ACT_SWEEP) |
                        (event_action_sel == `ATC_ACT_SYNC)) &
                       event_lines[event_line_group_sel];
  // flush and restart with the sweep
  assign timed_scan_with_restart = sweep_event & (event_action_sel == `ATC_ACT_SYNC);
  // reload when the previous pass has drained
  assign free_reload = continuous_sweep_flag & (pending == 4'h0);
  assign sweep_set   = (sweep_event | free_reload) ? scan_mask : 4'h0;

  // restarted clock ticks on this very edge
  // a count above a freshly lowered limit ticks at once instead of wrapping
  assign tick_now = timed_scan_with_restart | (div_cnt >= div_limit);

  // sync sweep joins at once, so channel 0 starts on the restart edge
  assign pend_view = pending | (timed_scan_with_restart ? sweep_set : 4'h0);

  assign start_onehot = pend_view & (~pend_view + 4'h1);

  always @* begin
    next_chan = 2'b00;
    if (start_onehot[1]) begin
      next_chan = 2'b01;
    end else if (start_onehot[2]) begin
      next_chan = 2'b10;
    end else if (start_onehot[3]) begin
      next_chan = 2'b11;
    end
  end

  always @* begin
    case (result_fmt)
      `ATC_FMT_R8:  next_word = {8'h00, raw_result[11:4]};
      `ATC_FMT_L12: next_word = {raw_result, 4'h0};
      `ATC_FMT_R12: next_word = {4'h0, raw_result};
      default:      next_word = {4'h0, raw_result};
    endcase
  end

  // reserved bits read zero through masks
  always @* begin
    next_rd = 8'h00;
    if (addr_ok) begin
      case (haddr[7:2])
        `ATC_IDX_CONV_B: next_rd = conv_b;
        `ATC_IDX_REF:    next_rd = ref_ctl;
        `ATC_IDX_EVT:    next_rd = evt_ctl;
        `ATC_IDX_DIV:    next_rd = div_ctl;
        default:         next_rd = 8'h00;
      endcase
    end
  end

  // bus slave, zero wait states, always OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wr_pend   <= 1'b0;
      wr_idx    <= 6'h00;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= req & hwrite & addr_ok;
      wr_idx    <= haddr[7:2];
      if (req & !hwrite) begin
        hrdata <= {24'h0000_00, next_rd};
      end
    end
  end

  // registers; unmapped writes are dropped
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_b  <= `ATC_RST_CONV_B;
      ref_ctl <= `ATC_RST_REF;
      evt_ctl <= `ATC_RST_EVT;
      div_ctl <= `ATC_RST_DIV;
    end else if (clk_en & wr_pend) begin
      case (wr_idx)
        `ATC_IDX_CONV_B: conv_b <= hwdata[7:0] & `ATC_MASK_CONV_B;
        `ATC_IDX_REF:    ref_ctl <= hwdata[7:0] & `ATC_MASK_REF;
        `ATC_IDX_EVT:    evt_ctl <= hwdata[7:0] & `ATC_MASK_EVT;
        `ATC_IDX_DIV:    div_ctl <= hwdata[7:0] & `ATC_MASK_DIV;
        default:         conv_b <= conv_b;
      endcase
    end
  end

  // converter clock and channel scheduler
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt        <= 9'h000;
      pending        <= 4'h0;
      conv_clk_tick  <= 1'b0;
      pipeline_flush <= 1'b0;
      conv_start     <= 1'b0;
      conv_channel   <= 2'b00;
    end else if (clk_en) begin
      div_cnt        <= tick_now ? 9'h000 : div_cnt + 9'h001;
      conv_clk_tick  <= tick_now;
      // flush pulse, pending requests survive it
      pipeline_flush <= timed_scan_with_restart;
      conv_start     <= tick_now & (pend_view != 4'h0);
      if (tick_now & (pend_view != 4'h0)) begin
        conv_channel <= next_chan;
      end
      // new requests win over the clear of a started channel
      pending <= (pend_view & ~(tick_now ? start_onehot : 4'h0)) | direct_set |
                 (timed_scan_with_restart ? 4'h0 : sweep_set);
    end
  end

  // high impedance only for low gain codes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_stage_low_imp <= 4'h0;
    end else if (clk_en) begin
      gain_stage_low_imp[0] <= conv_b[`ATC_CB_IMP] | (channel_gain[2:0] >= `ATC_GAIN_HIZ_LIMIT);
      gain_stage_low_imp[1] <= conv_b[`ATC_CB_IMP] | (channel_gain[5:3] >= `ATC_GAIN_HIZ_LIMIT);
      gain_stage_low_imp[2] <= conv_b[`ATC_CB_IMP] | (channel_gain[8:6] >= `ATC_GAIN_HIZ_LIMIT);
      gain_stage_low_imp[3] <= conv_b[`ATC_CB_IMP] | (channel_gain[11:9] >= `ATC_GAIN_HIZ_LIMIT);
    end
  end

  // reference outputs and formatted results
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reference_source_sel <= 3'b000;
      bandgap_request      <= 1'b0;
      temp_sensor_enable   <= 1'b0;
      result_valid         <= 1'b0;
      result_channel       <= 2'b00;
      result_word          <= 16'h0000;
    end else if (clk_en) begin
      reference_source_sel <= ref_ctl[`ATC_RF_SEL_HI:`ATC_RF_SEL_LO];
      bandgap_request      <= ref_ctl[`ATC_RF_BANDGAP];
      temp_sensor_enable   <= ref_ctl[`ATC_RF_TEMP];
      result_valid         <= raw_valid;
      if (raw_valid) begin
        result_channel <= raw_channel;
        result_word    <= next_word;
      end
    end
  end

endmodule // atc_ctrl

// >>> atc_ctrl_sva.sv
// assertion checker for the converter trigger and configuration block
`timescale 1ns/1ps
module atc_ctrl_sva (
  input logic        hclk,
  input logic        hresetn,
  input logic        hsel,
  input logic [31:0] haddr,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic [31:0] hwdata,
  input logic        hready,
  input logic [31:0] hrdata,
  input logic [11:0] channel_gain,
  input logic        raw_valid,
  input logic [1:0]  raw_channel,
  input logic [11:0] raw_result,
  input logic        conv_clk_tick,
  input logic        pipeline_flush,
  input logic        conv_start,
  input logic [1:0]  conv_channel,
  input logic [3:0]  gain_stage_low_imp,
  input logic [2:0]  reference_source_sel,
  input logic        bandgap_request,
  input logic        temp_sensor_enable,
  input logic        result_valid,
  input logic [1:0]  result_channel,
  input logic [15:0] result_word
);
  logic       wr_ref;
  logic [7:0] ref_shadow;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // shadow copy lands at the data phase edge, as the register does
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ref     <= 1'b0;
      ref_shadow <= 8'h00;
    end else begin
      wr_ref <= hsel && hready && htrans[1] && hwrite && haddr == 32'h0000_0008;
      if (wr_ref) ref_shadow <= hwdata[7:0];
    end
  end
  a_result_lag:
    assert property (raw_valid |=> result_valid && result_channel == $past(raw_channel))
    else $error("result does not follow raw data");
  a_result_form:
    assert property (result_valid |-> result_word == {4'h0, $past(raw_result)} ||
      result_word == {8'h00, $past(raw_result[11:4])} || result_word == {$past(raw_result), 4'h0})
    else $error("result word has no legal alignment");
  a_flush_tick:
    assert property (pipeline_flush |-> conv_clk_tick)
    else $error("flush without clock restart");
  a_flush_start:
    assert property (pipeline_flush |-> conv_start && conv_channel == 2'd0)
    else $error("flush not followed by channel 0 start");
  a_start_tick:
    assert property (conv_start |-> conv_clk_tick)
    else $error("start outside a converter tick");
  a_tick_space:
    assert property (conv_clk_tick |=> (!conv_clk_tick || pipeline_flush) [*3])
    else $error("converter ticks closer than four cycles");
  a_gain_low:
    assert property (channel_gain[2] ##1 channel_gain[2] |-> gain_stage_low_imp[0])
    else $error("large gain left in high impedance");
  a_ref_follow:
    assert property ({reference_source_sel, bandgap_request, temp_sensor_enable} ==
      {$past(ref_shadow[6:4]), $past(ref_shadow[1:0])})
    else $error("reference outputs differ from register");
  a_div_zero:
    assert property (hsel && hready && htrans[1] && !hwrite && haddr == 32'h0000_0010
      |=> hrdata[31:3] == 29'h0)
    else $error("divider reserved bits not zero");
  c_flush: cover property (pipeline_flush);
  c_last_ch: cover property (conv_start && conv_channel == 2'd3);
  c_result: cover property (result_valid);
endmodule // atc_ctrl_sva
bind atc_ctrl atc_ctrl_sva i_sva (.*);

// >>> atc_pipe_model.sv
// converter pipeline model answering conversion starts with raw results
`timescale 1ns/1ps
module atc_pipe_model (
  input  wire         hclk,
  input  wire         hresetn,
  input  wire         conv_start,
  input  wire  [1:0]  conv_channel,
  input  wire         pipeline_flush,
  output logic        raw_valid,
  output logic [1:0]  raw_channel,
  output logic [11:0] raw_result
);
  logic [2:0]  busy;
  logic [5:0]  chans;
  logic [11:0] last;
  assign raw_valid   = busy[2];
  assign raw_channel = chans[5:4];
  // idle result lines show the inverse of the last result, not a stale copy
  assign raw_result  = busy[2] ? {10'h294, chans[5:4]} : ~last;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy  <= 3'b000;
      chans <= 6'h00;
      last  <= 12'h000;
    end else begin
      busy  <= {pipeline_flush ? 2'b00 : busy[1:0], conv_start};
      chans <= {chans[3:0], conv_channel};
      if (busy[2]) last <= raw_result;
    end
  end
endmodule // atc_pipe_model

// >>> atc_tb.sv
// testbench for the converter trigger and configuration block
`timescale 1ns/1ps
`include "atc_defs.vh"
module testbench;
  localparam logic [31:0] ad_cb = `ATC_IDX_CONV_B * 4;
  localparam logic [31:0] ad_ref = `ATC_IDX_REF * 4;
  localparam logic [31:0] ad_evt = `ATC_IDX_EVT * 4;
  localparam logic [31:0] ad_div = `ATC_IDX_DIV * 4;
  logic hclk = 1'b0, hresetn = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'b00, raw_channel, conv_channel, result_channel;
  logic [2:0] hsize = 3'b010, reference_source_sel;
  logic [7:0] event_lines = 8'h00;
  logic [11:0] channel_gain = 12'h000, raw_result;
  logic [15:0] result_word, last_word, fexp[4] = '{16'h0A50, 16'h0A50, 16'h00A5, 16'hA500};
  logic hreadyout, hresp, raw_valid, conv_clk_tick, pipeline_flush, conv_start;
  logic bandgap_request, temp_sensor_enable, result_valid;
  logic [3:0] gain_stage_low_imp;
  logic [1:0] starts[$];
  int n_fail = 0, comparisons = 0, n_flush = 0, gap = 0, cnt = 0, cycles = 0;
  always #5 hclk = ~hclk;
  atc_ctrl i_dut (.hready(hreadyout), .*);
  atc_pipe_model i_pipe (.*);
  task give_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    cnt <= conv_clk_tick ? 1 : cnt + 1;
    if (conv_clk_tick) gap <= cnt;
    if (conv_start) starts.push_back(conv_channel);
    if (pipeline_flush) n_flush <= n_flush + 1;
    if (result_valid) last_word <= result_word;
    // the whole run needs well under this many cycles
    if (cycles == 20000) begin
      n_fail++;
      give_verdict;
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task bus(input logic [31:0] a, input logic w, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; htrans <= `ATC_HTRANS_NONSEQ; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 8'h00);
    chk("register read", r, exp);
    chk("bus response", hresp, 32'h0);
  endtask
  task run_ev(input logic [31:0] a, input logic [7:0] v, input logic [7:0] lines,
              input int n, input logic [15:0] seq, input bit exact);
    bus(a, 1'b1, v);
    starts.delete();
    @(posedge hclk) event_lines <= lines;
    @(posedge hclk) event_lines <= 8'h00;
    repeat (60) @(posedge hclk);
    if (exact) chk("start count", starts.size(), n);
    for (int i = 0; i < n; i++) chk("start channel", starts[i], seq[2*i+:2]);
  endtask
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 1; i <= 5; i++) rd(4 * i, 32'h0);
    bus(ad_div, 1'b1, 8'hFF);
    rd(ad_div, 32'h0000_0007);
    for (int d = 0; d < 3; d++) begin
      bus(ad_div, 1'b1, d);
      repeat (40) @(posedge hclk);
      chk("tick period", gap, 4 << d);
    end
    bus(ad_div, 1'b1, 8'h00);
    for (int c = 0; c < 5; c++) begin
      bus(ad_ref, 1'b1, {1'b0, c[2:0], 4'b0011});
      rd(ad_ref, {25'h0, c[2:0], 4'b0011});
      chk("reference outputs", {reference_source_sel, bandgap_request, temp_sensor_enable},
          {c[2:0], 2'b11});
    end
    channel_gain <= 12'h6C4;
    bus(ad_cb, 1'b1, 8'h00);
    chk("low impedance", gain_stage_low_imp, 4'h1);
    bus(ad_cb, 1'b1, 8'h80);
    // register lands at the last bus edge, the output one edge later
    repeat (2) @(posedge hclk);
    chk("low impedance", gain_stage_low_imp, 4'hF);
    for (int a = 0; a < 8; a++)
      run_ev(ad_evt, a, 8'h0F, (a < 5) ? a : (a < 7), 16'h00E4, 1);
    run_ev(ad_evt, 8'h14, 8'h3C, 4, 16'h00E4, 1);
    run_ev(ad_evt, 8'h3C, 8'hFF, 1, 16'h0000, 1);
    for (int s = 0; s < 4; s++)
      run_ev(ad_evt, {s[1:0], 6'h05}, 8'h01, s + 1, 16'h00E4, 1);
    run_ev(ad_evt, 8'hC5, 8'h02, 0, 16'h0000, 1);
    n_flush = 0;
    run_ev(ad_evt, 8'h46, 8'h01, 2, 16'h0004, 1);
    chk("flush count", n_flush, 1);
    for (int f = 0; f < 4; f++) begin
      bus(ad_cb, 1'b1, f << 1);
      run_ev(ad_evt, 8'h05, 8'h01, 1, 16'h0000, 1);
      chk("result word", last_word, fexp[f]);
    end
    bus(ad_evt, 1'b1, 8'hC0);
    run_ev(ad_cb, 8'h08, 8'h00, 6, 16'h04E4, 0);
    bus(ad_cb, 1'b1, 8'h00);
    give_verdict;
  end
endmodule // testbench
